// >>> snvsr_params.svh
// Purpose: Shared constants of the serial nvSRAM read and store control
// Assumes: 25 MHz system clock
// Notes: Timing counts are worked out from the clock rate
`ifndef SNVSR_PARAMS_SVH
`define SNVSR_PARAMS_SVH

`define SNVSR_CLK_HZ 25000000
`define SNVSR_ADDR_W 13
`define SNVSR_DEPTH 8192
`define SNVSR_FIFO_DEPTH 8
`define SNVSR_TYPE_CODE 4'ha
`define SNVSR_WP_TOP 2'h3
`define SNVSR_NV_WR_MS 8
`define SNVSR_RECALL_US 200
`define SNVSR_NV_WR_CYC ((`SNVSR_NV_WR_MS * (`SNVSR_CLK_HZ / 1000)))
`define SNVSR_RECALL_CYC (((`SNVSR_RECALL_US * (`SNVSR_CLK_HZ / 1000)) + 999) / 1000)

`endif

// >>> snvsr_pkg.sv
// Purpose: Types of the serial nvSRAM read and store control
// Assumes: Nothing
// Notes: Constants live in snvsr_params.svh
package snvsr_pkg;
  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK} snvsr_bus_t;
  typedef enum logic [1:0] {KIND_DEV, KIND_AHI, KIND_ALO, KIND_DATA} snvsr_kind_t;
  typedef enum logic [1:0] {NV_WAIT_UP, NV_RECALL, NV_RUN, NV_STORE} snvsr_nv_t;
endpackage : snvsr_pkg

// >>> snvsr_fifo.sv
// Purpose: Read prefetch FIFO between array and serial shifter
// Assumes: Single clock, synchronous reset
// Notes: Flush empties it in one cycle and wins over push
`timescale 1ns/10ps
module snvsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (2 ** PW) != DEPTH) begin : g_bad_depth
      $error("snvsr_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop = i_out_ready && o_out_valid;

  assign o_in_ready = (count_reg != FULL_CNT);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    count_reg <= FULL_CNT) else $error("FIFO count above depth");
endmodule : snvsr_fifo

// >>> snvsr_nvctl.sv
// Purpose: Power-loss store and power-up recall sequencer with nonvolatile cells
// Assumes: i_vcc_ok already synchronised, array read data one cycle late
// Notes: Store keeps running on capacitor power even if supply returns
`timescale 1ns/10ps
module snvsr_nvctl #(
  parameter int AW = 13,
  parameter int DEPTH = 8192,
  parameter int RECALL_CYC = 5000,
  parameter int NV_WR_CYC = 200000
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_vcc_ok,
  input wire logic i_dirty,
  output logic o_dirty_clr,
  output logic o_busy,
  output logic o_recall_busy,
  output logic o_cap_isolate,
  output logic [AW-1:0] o_rd_addr,
  input wire logic [7:0] i_sram_rd_data,
  output logic o_sram_wr_en,
  output logic [AW-1:0] o_sram_wr_addr,
  output logic [7:0] o_sram_wr_data
);
  localparam logic [AW:0] WALK_END = (AW+1)'(DEPTH);

  generate
    if (DEPTH + 2 > NV_WR_CYC || RECALL_CYC < DEPTH + 2) begin : g_bad_timing
      $error("snvsr_nvctl array walk does not fit the store or recall time");
    end
  endgenerate

  logic [7:0] nv_mem [DEPTH];
  snvsr_pkg::snvsr_nv_t state_reg;
  snvsr_pkg::snvsr_nv_t state_next;
  logic [AW:0] walk_reg;
  logic [31:0] timer_reg;
  logic st_wen_reg;
  logic [AW-1:0] pipe_addr_reg;
  logic [7:0] nv_q_reg;
  logic rc_wen_reg;
  wire walking = (walk_reg != WALK_END);
  wire state_change = (state_next != state_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      snvsr_pkg::NV_WAIT_UP: if (i_vcc_ok) state_next = snvsr_pkg::NV_RECALL;
      snvsr_pkg::NV_RECALL: begin
        if (!i_vcc_ok) begin
          state_next = snvsr_pkg::NV_WAIT_UP;
        end else if (timer_reg == 32'(RECALL_CYC - 1)) begin
          state_next = snvsr_pkg::NV_RUN;
        end
      end
      snvsr_pkg::NV_RUN: begin
        // Armed from reset with no enable; clean arrays skip the store
        if (!i_vcc_ok) begin
          state_next = i_dirty ? snvsr_pkg::NV_STORE : snvsr_pkg::NV_WAIT_UP;
        end
      end
      snvsr_pkg::NV_STORE: begin
        if (!walking && !st_wen_reg) state_next = snvsr_pkg::NV_WAIT_UP;
      end
      default: state_next = snvsr_pkg::NV_WAIT_UP;
    endcase
  end

  assign o_rd_addr = walk_reg[AW-1:0];
  assign o_sram_wr_en = rc_wen_reg;
  assign o_sram_wr_addr = pipe_addr_reg;
  assign o_sram_wr_data = nv_q_reg;

  always_ff @(posedge i_ref_clk) begin
    if (st_wen_reg) begin
      nv_mem[pipe_addr_reg] <= i_sram_rd_data;
    end
    nv_q_reg <= nv_mem[walk_reg[AW-1:0]];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= snvsr_pkg::NV_WAIT_UP;
      walk_reg <= '0;
      timer_reg <= '0;
      st_wen_reg <= 1'b0;
      rc_wen_reg <= 1'b0;
      pipe_addr_reg <= '0;
      o_dirty_clr <= 1'b0;
      o_busy <= 1'b1;
      o_recall_busy <= 1'b0;
      o_cap_isolate <= 1'b1;
    end else begin
      state_reg <= state_next;
      walk_reg <= state_change ? '0 : (walking ? walk_reg + 1'b1 : walk_reg);
      timer_reg <= state_change ? '0 : timer_reg + 32'h1;
      st_wen_reg <= (state_reg == snvsr_pkg::NV_STORE) && walking && !state_change;
      rc_wen_reg <= (state_reg == snvsr_pkg::NV_RECALL) && walking && !state_change;
      pipe_addr_reg <= walk_reg[AW-1:0];
      o_dirty_clr <= (state_next == snvsr_pkg::NV_STORE) && state_change;
      o_busy <= (state_next != snvsr_pkg::NV_RUN);
      o_recall_busy <= (state_next == snvsr_pkg::NV_RECALL);
      o_cap_isolate <= (state_next == snvsr_pkg::NV_STORE) ||
                       (state_next == snvsr_pkg::NV_WAIT_UP);
    end
  end

  AST_ISOLATE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::NV_RUN) && !i_vcc_ok |=> o_cap_isolate && o_busy)
    else $error("Capacitor not isolated on supply loss");
  AST_SKIP_CLEAN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::NV_RUN) && !i_vcc_ok && !i_dirty
    |=> (state_reg == snvsr_pkg::NV_WAIT_UP) && !o_dirty_clr)
    else $error("Store started on a clean array");
  AST_STORE_ALL: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::NV_STORE) && state_change |-> !walking && timer_reg > DEPTH)
    else $error("Store ended before the whole array was copied");
  AST_STORE_BOUND: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::NV_STORE) |-> timer_reg < 32'(NV_WR_CYC))
    else $error("Store exceeded the nonvolatile write cycle time");
  AST_RECALL_TIME: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::NV_RECALL) && i_vcc_ok
    |=> o_recall_busy == ($past(timer_reg) != 32'(RECALL_CYC - 1)))
    else $error("Recall length differs from recall duration");
endmodule : snvsr_nvctl

// >>> snvsr_top.sv
// Purpose: Two-wire serial nvSRAM slave with reads, power-loss store and recall
// Assumes: SCL, SDA and straps arrive asynchronously; SCL far slower than i_ref_clk
// Notes: SDA is open drain, o_sda_oe high pulls the line low
//
// How it works
// - After each read byte leaves, address counter steps by one; next byte follows ack.
// - Every master ack streams another byte, with no length limit.
// - Device address with read bit set is acked, then loaded byte goes out.
// - Master nack ends the read; device releases SDA and idles.
// - Power-loss store is armed from reset without any setting.
// - Supply below trip level isolates capacitor pin and starts a store if the array is dirty.
// - Completed written bytes survive power loss; a partial byte is dropped.
// - Store is skipped unless a write happened since the last store.
// - Store copies the whole array to nonvolatile cells.
// - Recall request latched at power-up or drop; runs recall duration after supply returns.
// - All serial commands are ignored while recall runs.
// - First byte: type code bits 7-4, select bits 2-1, read/write bit 0.
// - Bytes are eight bits MSB first; ninth clock carries ack; nack aborts.
// - A 13-bit address latch increments per byte and feeds current reads.
// - Address counter wraps from top address to zero.
`timescale 1ns/10ps
`include "snvsr_params.svh"
module snvsr_top #(
  parameter int AW = `SNVSR_ADDR_W,
  parameter int DEPTH = `SNVSR_DEPTH,
  parameter int FIFO_DEPTH = `SNVSR_FIFO_DEPTH,
  parameter int NV_WR_CYC = `SNVSR_NV_WR_CYC,
  parameter int RECALL_CYC = `SNVSR_RECALL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [1:0] i_dev_sel,
  input wire logic i_write_protect,
  input wire logic i_vcc_ok,
  output logic o_cap_isolate,
  output logic o_nv_busy,
  output logic o_recall_busy
);
  localparam logic [AW-1:0] ADDR_ONE = {{(AW-1){1'b0}}, 1'b1};

  generate
    if (AW <= 8 || AW > 16 || (2 ** AW) != DEPTH) begin : g_bad_size
      $error("snvsr_top needs a 9 to 16 bit address and a matching depth");
    end
  endgenerate

  // Two-stage synchronisers; logic reads the second stage and, for SCL and SDA, a delayed copy of it
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic vcc_s1_reg, vcc_s2_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic [1:0] sel_s1_reg, sel_s2_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      vcc_s1_reg <= 1'b0;
      vcc_s2_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
    end else begin
      scl_s1_reg <= i_scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= i_sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      vcc_s1_reg <= i_vcc_ok;
      vcc_s2_reg <= vcc_s1_reg;
      wp_s1_reg <= i_write_protect;
      wp_s2_reg <= wp_s1_reg;
      sel_s1_reg <= i_dev_sel;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  snvsr_pkg::snvsr_bus_t state_reg, state_next;
  snvsr_pkg::snvsr_kind_t kind_reg, kind_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic ack_ok_reg;
  logic ack_seen_reg;
  logic rd_mode_reg;
  logic oe_next;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] fetch_addr_reg;
  logic fetch_pend_reg;
  logic dirty_reg;
  logic [7:0] sram_mem [DEPTH];
  logic [7:0] sram_q_reg;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic nv_dirty_clr, nv_wr_en;
  logic [AW-1:0] nv_rd_addr, nv_wr_addr;
  logic [7:0] nv_wr_data;

  // Edges and bus conditions; no timeout anywhere, so a parked clock is safe
  wire scl_rise = scl_s2_reg && !scl_d_reg;
  wire scl_fall = !scl_s2_reg && scl_d_reg;
  wire bus_start = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
  wire bus_stop = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;
  wire nv_busy = o_nv_busy;
  wire [7:0] rx_byte = {rx_sh_reg[6:0], sda_s2_reg};
  wire in_rx = (state_reg == snvsr_pkg::BUS_RX);
  wire in_tx = (state_reg == snvsr_pkg::BUS_TX);
  wire byte_end = in_rx && scl_rise && (bit_cnt_reg == 4'h7);
  wire dev_match = (rx_byte[7:4] == `SNVSR_TYPE_CODE) && (rx_byte[2:1] == sel_s2_reg);
  wire wr_blocked = wp_s2_reg && (addr_reg[AW-1:AW-2] == `SNVSR_WP_TOP);
  wire bus_wr = byte_end && (kind_reg == snvsr_pkg::KIND_DATA) && !nv_busy;
  wire mem_bus_we = bus_wr && !wr_blocked;
  wire tx_done = in_tx && scl_fall && (bit_cnt_reg == 4'h8);
  wire load_tx = (state_next == snvsr_pkg::BUS_TX) && !in_tx;
  wire [7:0] tx_load = fifo_out_valid ? fifo_out_data : 8'hff;
  wire fetch_issue = rd_mode_reg && fifo_in_ready && !fetch_pend_reg && !nv_busy;
  wire mem_we = nv_wr_en || mem_bus_we;
  wire [AW-1:0] mem_waddr = nv_wr_en ? nv_wr_addr : addr_reg;
  wire [7:0] mem_wdata = nv_wr_en ? nv_wr_data : rx_byte;
  wire [AW-1:0] mem_raddr = nv_busy ? nv_rd_addr : fetch_addr_reg;
  wire kind_step = (kind_reg == snvsr_pkg::KIND_DEV) ? 1'b1 : 1'b0;

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    oe_next = o_sda_oe;
    if (nv_busy || bus_stop) begin
      state_next = snvsr_pkg::BUS_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      state_next = snvsr_pkg::BUS_RX;
      kind_next = snvsr_pkg::KIND_DEV;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        snvsr_pkg::BUS_IDLE: oe_next = 1'b0;
        snvsr_pkg::BUS_RX: begin
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            state_next = ack_ok_reg ? snvsr_pkg::BUS_RX_ACK : snvsr_pkg::BUS_IDLE;
            oe_next = ack_ok_reg;
          end
        end
        snvsr_pkg::BUS_RX_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            if (kind_step && rd_mode_reg) begin
              state_next = snvsr_pkg::BUS_TX;
              oe_next = !tx_load[7];
            end else begin
              state_next = snvsr_pkg::BUS_RX;
              case (kind_reg)
                snvsr_pkg::KIND_DEV: kind_next = snvsr_pkg::KIND_AHI;
                snvsr_pkg::KIND_AHI: kind_next = snvsr_pkg::KIND_ALO;
                default: kind_next = snvsr_pkg::KIND_DATA;
              endcase
            end
          end
        end
        snvsr_pkg::BUS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_next = snvsr_pkg::BUS_TX_ACK;
              oe_next = 1'b0;
            end else begin
              oe_next = !tx_sh_reg[6];
            end
          end
        end
        snvsr_pkg::BUS_TX_ACK: begin
          if (scl_fall) begin
            state_next = ack_seen_reg ? snvsr_pkg::BUS_TX : snvsr_pkg::BUS_IDLE;
            oe_next = ack_seen_reg && !tx_load[7];
          end
        end
        default: begin
          state_next = snvsr_pkg::BUS_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= snvsr_pkg::BUS_IDLE;
      kind_reg <= snvsr_pkg::KIND_DEV;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      o_sda_oe <= oe_next;
      o_sda_out <= 1'b0;
      if (state_next != state_reg || bus_start) begin
        bit_cnt_reg <= 4'h0;
      end else if (scl_rise && (in_rx || in_tx)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'hff;
      ack_ok_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
    end else begin
      if (in_rx && scl_rise) rx_sh_reg <= rx_byte;
      if (load_tx) tx_sh_reg <= tx_load;
      else if (in_tx && scl_fall) tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
      if (byte_end) ack_ok_reg <= (kind_reg == snvsr_pkg::KIND_DEV) ? dev_match : 1'b1;
      if (state_reg == snvsr_pkg::BUS_TX_ACK && scl_rise) ack_seen_reg <= !sda_s2_reg;
      if (nv_busy || bus_start || bus_stop || state_next == snvsr_pkg::BUS_IDLE) begin
        rd_mode_reg <= 1'b0;
      end else if (byte_end && kind_reg == snvsr_pkg::KIND_DEV && dev_match) begin
        rd_mode_reg <= rx_byte[0];
      end
    end
  end

  // Address latch: loaded by the dummy write, stepped per byte, wraps naturally
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      addr_reg <= '0;
    end else if (byte_end && !nv_busy && kind_reg == snvsr_pkg::KIND_AHI) begin
      addr_reg <= {rx_byte[AW-9:0], addr_reg[7:0]};
    end else if (byte_end && !nv_busy && kind_reg == snvsr_pkg::KIND_ALO) begin
      addr_reg <= {addr_reg[AW-1:8], rx_byte};
    end else if (bus_wr || tx_done) begin
      addr_reg <= addr_reg + ADDR_ONE;
    end
  end

  // Only whole bytes reach the array, so a torn last byte is simply never written
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) sram_mem[mem_waddr] <= mem_wdata;
    sram_q_reg <= sram_mem[mem_raddr];
  end

  // Set wins over the clear issued when a store begins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) dirty_reg <= 1'b0;
    else if (mem_bus_we) dirty_reg <= 1'b1;
    else if (nv_dirty_clr) dirty_reg <= 1'b0;
  end

  // Prefetch runs ahead of the shifter while a read is open
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fetch_addr_reg <= '0;
      fetch_pend_reg <= 1'b0;
    end else if (!rd_mode_reg) begin
      fetch_addr_reg <= addr_reg;
      fetch_pend_reg <= 1'b0;
    end else begin
      fetch_pend_reg <= fetch_issue;
      if (fetch_issue) fetch_addr_reg <= fetch_addr_reg + ADDR_ONE;
    end
  end

  snvsr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_flush(!rd_mode_reg),
    .i_in_valid(fetch_pend_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(sram_q_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load_tx),
    .o_out_data(fifo_out_data)
  );

  snvsr_nvctl #(.AW(AW), .DEPTH(DEPTH), .RECALL_CYC(RECALL_CYC), .NV_WR_CYC(NV_WR_CYC)) u_nv (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_vcc_ok(vcc_s2_reg),
    .i_dirty(dirty_reg),
    .o_dirty_clr(nv_dirty_clr),
    .o_busy(o_nv_busy),
    .o_recall_busy(o_recall_busy),
    .o_cap_isolate(o_cap_isolate),
    .o_rd_addr(nv_rd_addr),
    .i_sram_rd_data(sram_q_reg),
    .o_sram_wr_en(nv_wr_en),
    .o_sram_wr_addr(nv_wr_addr),
    .o_sram_wr_data(nv_wr_data)
  );

  AST_ADDR_ADV: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    tx_done |=> addr_reg == $past(addr_reg) + ADDR_ONE)
    else $error("Address did not step after a read byte");
  AST_RD_STREAM: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::BUS_TX_ACK) && scl_fall && ack_seen_reg && !nv_busy
    |=> in_tx && (bit_cnt_reg == 4'h0))
    else $error("Master ack did not start another byte");
  AST_RD_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::BUS_RX_ACK) && scl_fall && kind_step && rd_mode_reg &&
    fifo_out_valid && !nv_busy && !bus_stop
    |=> in_tx && (tx_sh_reg == $past(fifo_out_data)) && (o_sda_oe == !tx_sh_reg[7]))
    else $error("Read did not shift out the loaded byte");
  AST_NACK_END: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == snvsr_pkg::BUS_TX_ACK) && scl_fall && !ack_seen_reg
    |=> (state_reg == snvsr_pkg::BUS_IDLE) && !o_sda_oe ##1 !rd_mode_reg)
    else $error("Nack did not end the read");
  AST_DEV_NACK: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    in_rx && scl_fall && (bit_cnt_reg == 4'h8) && (kind_reg == snvsr_pkg::KIND_DEV) &&
    !ack_ok_reg |=> (state_reg == snvsr_pkg::BUS_IDLE) && !o_sda_oe)
    else $error("Foreign device address was not left alone");
  AST_DIRTY_SET: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    mem_bus_we |=> dirty_reg)
    else $error("Write did not mark the array dirty");
  AST_NV_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    nv_busy && $past(nv_busy) |-> !o_sda_oe)
    else $error("SDA driven during store or recall");
  AST_RECALL_IGNORE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_recall_busy && $past(o_recall_busy)
    |-> (state_reg == snvsr_pkg::BUS_IDLE) && !rd_mode_reg && !mem_bus_we)
    else $error("Bus command acted on during recall");
endmodule : snvsr_top

// >>> snvsr_master.sv
// Purpose: Bus master model driving the serial clock and data
// Assumes: Data wire has a pull-up; bit period 320 ns
// Notes: The bench calls these tasks through the instance
`timescale 1ns/10ps
module snvsr_master (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge i_ref_clk);
  endtask : half
  task automatic clk_bit(input logic b, output logic s);
    o_pull = !b;
    half();
    o_scl = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    s = i_sda;
    repeat (2) @(negedge i_ref_clk);
    o_scl = 1'b0;
  endtask : clk_bit
  task automatic start();
    o_pull = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_pull = 1'b1;
    half();
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    o_pull = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_pull = 1'b0;
    half();
  endtask : stop
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask : put
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!ack, s);
  endtask : get
endmodule : snvsr_master

// >>> serial_nvsram_read_and_store_control_bench.sv
// Purpose: Self-checking bench for reads, power-loss store and recall
// Assumes: Short store count; recall count raised to 8300 so the array walk fits
// Notes: Data wire resolved as open drain with pull-up
`timescale 1ns/10ps
module serial_nvsram_read_and_store_control_bench;
  localparam int CYC = 8300;
  logic clk = 1'b0, rst = 1'b1, vcc = 1'b0, wp = 1'b0, scl, pull, oe, so, iso, busy, rbusy, ack;
  logic [1:0] sel;
  logic [7:0] d[4], x, r;
  logic [12:0] a;
  int err_count = 0, checks = 0, n, nr;
  wire sda = !(oe | pull);
  always #20 clk = !clk;
  snvsr_top #(.NV_WR_CYC(CYC), .RECALL_CYC(CYC)) DUT (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_scl(scl), .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe), .i_dev_sel(sel),
    .i_write_protect(wp), .i_vcc_ok(vcc), .o_cap_isolate(iso), .o_nv_busy(busy),
    .o_recall_busy(rbusy));
  snvsr_master m (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic wait_idle();
    n = 0;
    nr = 0;
    while (busy !== 1'b0) begin
      @(negedge clk);
      n++;
      if (rbusy === 1'b1) nr++;
      if (n > 3 * CYC) begin
        check("idle timeout", 16'h1, 16'h0);
        conclude();
      end
    end
  endtask : wait_idle
  function automatic logic [7:0] dev(input logic rw);
    return {4'ha, 1'b1, sel, rw};
  endfunction : dev
  task automatic setup(input logic [12:0] ad);
    m.start();
    m.put(dev(1'b0), ack);
    check("dev_w ack", ack, 16'h1);
    m.put({3'h0, ad[12:8]}, ack);
    check("addr_hi ack", ack, 16'h1);
    m.put(ad[7:0], ack);
    check("addr_lo ack", ack, 16'h1);
  endtask : setup
  task automatic rd_seq(input int k, input int base);
    m.start();
    m.put(dev(1'b1), ack);
    check("dev_r ack", ack, 16'h1);
    check("sda value", so, 16'h0);
    for (int i = 0; i < k; i++) begin
      m.get(i < k - 1, r);
      check("read byte", r, d[base + i]);
    end
    m.stop();
    check("released", oe, 16'h0);
  endtask : rd_seq
  initial begin
    n = $urandom(32'h10ad);
    sel = 2'($urandom);
    repeat (8) @(negedge clk);
    rst = 1'b0;
    vcc = 1'b1;
    wait_idle();
    check("recall length", nr, CYC);
    setup(13'h1fff);
    x = 8'($urandom);
    m.put(x, ack);
    m.stop();
    wp = 1'b1;
    setup(13'h1fff);
    m.put(~x, ack);
    check("protected ack", ack, 16'h1);
    m.stop();
    wp = 1'b0;
    d[0] = x;
    setup(13'h1fff);
    rd_seq(1, 0);
    for (int p = 0; p < 2; p++) begin
      a = p ? 13'($urandom) : 13'h1ffe;
      foreach (d[i]) d[i] = 8'($urandom);
      setup(a);
      foreach (d[i]) m.put(d[i], ack);
      m.stop();
      setup(a);
      rd_seq(2, 0);
      rd_seq(2, 2);
    end
    m.start();
    m.put({4'ha, 1'b1, ~sel, 1'b1}, ack);
    check("foreign select", ack, 16'h0);
    m.stop();
    setup(a);
    x = 8'($urandom);
    m.put(x, ack);
    repeat (4) m.clk_bit(!x[0], r[0]);
    vcc = 1'b0;
    repeat (4) @(negedge clk);
    check("isolate", iso, 16'h1);
    m.start();
    m.put(dev(1'b0), ack);
    check("ignored in store", ack, 16'h0);
    m.stop();
    vcc = 1'b1;
    wait_idle();
    check("store span", (n > CYC + 7000) && (n < 2 * CYC + 50), 16'h1);
    d[0] = x;
    setup(a);
    rd_seq(2, 0);
    vcc = 1'b0;
    repeat (20) @(negedge clk);
    vcc = 1'b1;
    repeat (40) @(negedge clk);
    check("recall busy", rbusy, 16'h1);
    m.start();
    m.put(dev(1'b1), ack);
    check("ignored in recall", ack, 16'h0);
    m.stop();
    wait_idle();
    check("store skipped", n < CYC, 16'h1);
    setup(a);
    rd_seq(2, 0);
    conclude();
  end
endmodule : serial_nvsram_read_and_store_control_bench
